/* rtl/ilb_interconnect.sv */
// Purpose: local, fast and slow bus interconnect with init-lock gating
// Assumes: masters hold valid until their done pulse, then drop it
// Notes: slow writes are posted; software must read back to order them
`timescale 1ns/1ps
`default_nettype none
module ilb_interconnect #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // masters: cpu on local bus, fast-bus master, slow-bus master
  input wire ilb_pkg::ilb_req_t [ilb_pkg::NMST-1:0] mst_req,
  output var ilb_pkg::ilb_rsp_t [ilb_pkg::NMST-1:0] mst_rsp,
  // local bus slave side
  output ilb_pkg::ilb_bus_t lm_bus,
  input wire logic [31:0] lm_rdata,
  // fast bus slave side
  output ilb_pkg::ilb_bus_t fb_bus,
  input wire logic [31:0] fb_rdata,
  // slow bus slave side
  output ilb_pkg::ilb_bus_t sb_bus,
  input wire logic [31:0] sb_rdata,
  // system-wide lock line
  output logic init_lock,
  // ethernet interrupt cause source
  input wire logic eth_cause_valid,
  input wire logic [31:0] eth_cause,
  output logic eth_pending
);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int LF_ISSUE = ilb_pkg::LF_CYC + 1;
  localparam logic [PW:0] F_FULL = (PW + 1)'(FIFO_DEPTH);
  localparam logic [PW:0] F_ONE = (PW + 1)'(1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOP = 3'b001,
    ST_SLOW = 3'b010,
    ST_CAP = 3'b011,
    ST_RESP = 3'b100
  } ilb_state_t;

  ilb_state_t st_r;
  ilb_state_t st_nxt;
  logic [3:0] cnt_r;
  logic [1:0] src_r;
  ilb_pkg::ilb_tgt_t tgt_r;
  logic wr_r;
  logic err_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] wdt_r;
  logic pend_r;
  ilb_pkg::ilb_rsp_t [ilb_pkg::NMST-1:0] rsp_r;
  ilb_pkg::ilb_bus_t lm_r;
  ilb_pkg::ilb_bus_t fb_r;
  logic [31:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] fcnt_r;
  logic sl_busy;
  logic sl_done;
  logic sl_acc;
  logic [31:0] sl_rdata;

  // ---------------------------------------------------------------
  // arbitration and permission
  // ---------------------------------------------------------------
  // fixed priority keeps the cpu ahead; lower masters can starve
  wire logic [1:0] gnt = mst_req[0].valid ? ilb_pkg::MST_CPU :
                         mst_req[1].valid ? ilb_pkg::MST_FAST :
                         ilb_pkg::MST_SLOW;
  wire logic any_req = mst_req[0].valid | mst_req[1].valid |
                       mst_req[2].valid;
  wire ilb_pkg::ilb_req_t g_req = mst_req[gnt];
  wire logic take = (st_r == ST_IDLE) && any_req;
  wire ilb_pkg::ilb_tgt_t g_tgt = ilb_pkg::tgt_of(g_req.addr);
  wire logic g_prot = g_req.write && ilb_pkg::is_prot(g_req.addr);
  wire logic g_wdt = g_req.write && (g_req.addr == ilb_pkg::WDT_ADDR);
  // the lock line is sampled at grant, so a posted unlock may miss it
  wire logic g_err = (g_prot && (init_lock || !g_req.sup)) ||
                     (g_wdt && !g_req.sup);

  // ---------------------------------------------------------------
  // routing
  // ---------------------------------------------------------------
  wire logic hop_end = (st_r == ST_HOP) && (cnt_r == 4'h0);
  wire logic ok_end = hop_end && !err_r;
  wire logic fifo_hit = (tgt_r == ilb_pkg::TGT_FAST) &&
                        (addr_r == ilb_pkg::ETH_FIFO_ADDR);
  wire logic slow_go = ok_end && (tgt_r == ilb_pkg::TGT_SLOW) && !sl_busy;
  wire logic fast_go = ok_end && (tgt_r == ilb_pkg::TGT_FAST) && !fifo_hit;
  wire logic local_go = ok_end && (tgt_r == ilb_pkg::TGT_LOCAL);
  wire logic fifo_go = ok_end && fifo_hit;
  wire logic pop = fifo_go && !wr_r && (fcnt_r != '0);
  // a posted slow write is answered as soon as it enters the stage
  wire logic fin = (hop_end && err_r) || (slow_go && wr_r) ||
                   fifo_go || (st_r == ST_CAP) ||
                   ((st_r == ST_SLOW) && sl_done);
  wire logic [31:0] fin_rdata =
    (st_r == ST_CAP) ? ((tgt_r == ilb_pkg::TGT_FAST) ? fb_rdata : lm_rdata) :
    (st_r == ST_SLOW) ? sl_rdata :
    pop ? fifo_mem[rp_r] : 32'h0000_0000;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (take) st_nxt = ST_HOP;
      ST_HOP: begin
        if (fin) st_nxt = ST_RESP;
        else if (slow_go) st_nxt = ST_SLOW;
        else if (fast_go || local_go) st_nxt = ST_CAP;
      end
      ST_SLOW: if (sl_done) st_nxt = ST_RESP;
      ST_CAP: st_nxt = ST_RESP;
      ST_RESP: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (take) cnt_r <= ilb_pkg::hop_cyc(gnt, g_tgt) - 4'h1;
      else if (st_r == ST_HOP && cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_r <= 2'h0;
      tgt_r <= ilb_pkg::TGT_LOCAL;
      wr_r <= 1'b0;
      err_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
    end else if (take) begin
      src_r <= gnt;
      tgt_r <= g_tgt;
      wr_r <= g_req.write;
      err_r <= g_err;
      addr_r <= g_req.addr;
      wdata_r <= g_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // bus drives and answers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fb_r <= '0;
      lm_r <= '0;
    end else begin
      fb_r.req <= fast_go;
      lm_r.req <= local_go;
      if (fast_go || local_go) begin
        fb_r.write <= wr_r;
        fb_r.addr <= addr_r;
        fb_r.wdata <= wdata_r;
        lm_r.write <= wr_r;
        lm_r.addr <= addr_r;
        lm_r.wdata <= wdata_r;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rsp_r <= '0;
    end else begin
      for (int i = 0; i < ilb_pkg::NMST; i++) begin
        rsp_r[i].done <= fin && (src_r == 2'(i));
        if (fin && src_r == 2'(i)) begin
          rsp_r[i].err <= err_r;
          rsp_r[i].rdata <= fin_rdata;
        end
      end
    end
  end

  assign mst_rsp = rsp_r;
  assign fb_bus = fb_r;
  assign lm_bus = lm_r;

  // ---------------------------------------------------------------
  // slow stage and system control registers
  // ---------------------------------------------------------------
  wire logic int_hit = (sb_bus.addr == ilb_pkg::WDT_ADDR) ||
                       (sb_bus.addr == ilb_pkg::ETH_SRV_ADDR);
  wire logic [31:0] int_rdata = (sb_bus.addr == ilb_pkg::WDT_ADDR) ? wdt_r :
                                (32'(pend_r) << ilb_pkg::ETH_PEND_BIT);
  wire logic wdt_wr = sl_acc && sb_bus.write &&
                      (sb_bus.addr == ilb_pkg::WDT_ADDR);
  wire logic eth_clr = sl_acc && sb_bus.write &&
                       (sb_bus.addr == ilb_pkg::ETH_SRV_ADDR) &&
                       sb_bus.wdata[ilb_pkg::ETH_CLR_BIT];
  wire logic eth_push = eth_cause_valid && (fcnt_r != F_FULL);
  wire logic eth_set = eth_push || (pop && fcnt_r > F_ONE);

  ilb_slow_stage #(
    .LAT(ilb_pkg::FS_CYC)
  ) u_slow (
    .clock(clock),
    .resetn(resetn),
    .push(slow_go),
    .push_write(wr_r),
    .push_addr(addr_r),
    .push_wdata(wdata_r),
    .busy(sl_busy),
    .done(sl_done),
    .rdata(sl_rdata),
    .int_hit(int_hit),
    .int_rdata(int_rdata),
    .int_acc(sl_acc),
    .sb_bus(sb_bus),
    .sb_rdata(sb_rdata)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) wdt_r <= ilb_pkg::WDT_RESET;
    else if (wdt_wr) wdt_r <= sb_bus.wdata;
  end

  assign init_lock = wdt_r[ilb_pkg::INIT_LOCK_BIT];

  // set wins over the software clear, so no cause is lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) pend_r <= 1'b0;
    else pend_r <= eth_set | (pend_r & ~eth_clr);
  end

  assign eth_pending = pend_r;

  // causes arriving while full are dropped
  always_ff @(posedge clock) begin
    if (eth_push) fifo_mem[wp_r] <= eth_cause;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      fcnt_r <= '0;
    end else begin
      if (eth_push) wp_r <= wp_r + PW'(1);
      if (pop) rp_r <= rp_r + PW'(1);
      fcnt_r <= fcnt_r + (PW + 1)'(eth_push) - (PW + 1)'(pop);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_bad_take;
    take && g_err;
  endsequence

  a_lock_refuse: assert property (take && g_prot && init_lock |=> err_r)
    else $error("protected write passed with lock set");
  a_user_refuse: assert property (take && g_prot && !g_req.sup |=> err_r)
    else $error("protected write passed outside supervisor mode");
  a_refuse_quiet: assert property (s_bad_take |=>
    (!fb_r.req && !lm_r.req && !slow_go) until_with fin)
    else $error("refused write reached a bus");
  a_refuse_bound: assert property (s_bad_take |-> ##[1:20] fin)
    else $error("refused write not answered");
  a_err_return: assert property (fin && err_r && src_r == ilb_pkg::MST_CPU
    |=> mst_rsp[0].done && mst_rsp[0].err)
    else $error("bus error not returned to cpu");
  a_lock_line: assert property (wdt_wr |=>
    init_lock == $past(sb_bus.wdata[ilb_pkg::INIT_LOCK_BIT]))
    else $error("lock line does not follow watchdog write");
  a_posted_ack: assert property (slow_go && wr_r |=>
    (st_r == ST_RESP) && sl_busy)
    else $error("slow write not posted");
  a_fast_hop: assert property (take && gnt == ilb_pkg::MST_CPU &&
    g_tgt == ilb_pkg::TGT_FAST && !g_err &&
    g_req.addr != ilb_pkg::ETH_FIFO_ADDR |-> ##[LF_ISSUE:LF_ISSUE] fb_r.req)
    else $error("cpu fast access not issued after bridge hop");
  a_fifo_rearm: assert property (pop && fcnt_r > F_ONE |=> eth_pending)
    else $error("pending not raised with entries left");

endmodule
`default_nettype wire

/* rtl/ilb_pkg.sv */
// Purpose: shared constants, types and decoders of the bus interconnect
// Assumes: one 200 MHz clock; bus rates become per-hop wait counts
// Notes: addresses are byte addresses on 32-bit words
package ilb_pkg;

  // ---------------------------------------------------------------
  // rates and hop waits
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FAST_MHZ = 96;
  localparam int SLOW_MHZ = 48;
  // a hop lasts at least one beat of the slower side, so round up
  localparam int LF_CYC = (CLK_MHZ + FAST_MHZ - 1) / FAST_MHZ;
  localparam int FS_CYC = (CLK_MHZ + SLOW_MHZ - 1) / SLOW_MHZ;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [11:0] SLOW_REGION = 12'hF00;
  localparam logic [3:0] LOCAL_REGION = 4'hD;
  localparam logic [31:0] WDT_ADDR = 32'hF000_0020;
  localparam logic [31:0] WDT_RESET = 32'h0000_0000;
  localparam int INIT_LOCK_BIT = 0;
  localparam logic [31:0] ETH_SRV_ADDR = 32'hF000_0090;
  localparam int ETH_CLR_BIT = 14;
  localparam int ETH_PEND_BIT = 13;
  localparam logic [31:0] ETH_FIFO_ADDR = 32'hF020_0000;
  // pci, ext bus and sync serial clock control, second watchdog word
  localparam int NPROT = 4;
  localparam logic [31:0] PROT_ADDR [NPROT] = '{
    32'hF040_0000, 32'hF800_0000, 32'hF000_0A00, 32'hF000_0024};

  // ---------------------------------------------------------------
  // masters and carriers
  // ---------------------------------------------------------------
  localparam int NMST = 3;
  localparam logic [1:0] MST_CPU = 2'h0;
  localparam logic [1:0] MST_FAST = 2'h1;
  localparam logic [1:0] MST_SLOW = 2'h2;

  typedef enum logic [1:0] {
    TGT_LOCAL = 2'b00,
    TGT_FAST = 2'b01,
    TGT_SLOW = 2'b10
  } ilb_tgt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic sup;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ilb_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } ilb_rsp_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ilb_bus_t;

  // ---------------------------------------------------------------
  // decoders
  // ---------------------------------------------------------------
  function automatic ilb_tgt_t tgt_of(input logic [31:0] addr);
    if (addr[31:20] == SLOW_REGION) return TGT_SLOW;
    if (addr[31:28] == LOCAL_REGION) return TGT_LOCAL;
    return TGT_FAST;
  endfunction

  function automatic logic is_prot(input logic [31:0] addr);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NPROT; i++) hit = hit | (addr == PROT_ADDR[i]);
    return hit;
  endfunction

  // waits before the target bus is reached
  function automatic logic [3:0] hop_cyc(input logic [1:0] src,
                                         input ilb_tgt_t tgt);
    logic [3:0] lf;
    logic [3:0] fs;
    lf = 4'(LF_CYC);
    fs = 4'(FS_CYC);
    case (src)
      MST_CPU: return (tgt == TGT_LOCAL) ? 4'h1 : lf;
      MST_FAST: return (tgt == TGT_LOCAL) ? lf : 4'h1;
      default: return (tgt == TGT_LOCAL) ? lf + fs :
                      (tgt == TGT_FAST) ? fs : 4'h1;
    endcase
  endfunction

endpackage

/* rtl/ilb_slow_stage.sv */
// Purpose: single-entry slow-bus stage behind the slow/fast bridge
// Assumes: push only while busy is low
// Notes: writes are posted here, so they land after the master is told
`timescale 1ns/1ps
`default_nettype none
module ilb_slow_stage #(
  parameter int LAT = ilb_pkg::FS_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // from the bridge
  input wire logic push,
  input wire logic push_write,
  input wire logic [31:0] push_addr,
  input wire logic [31:0] push_wdata,
  output logic busy,
  output logic done,
  output logic [31:0] rdata,
  // registers held inside the system control unit
  input wire logic int_hit,
  input wire logic [31:0] int_rdata,
  output logic int_acc,
  // slow peripheral bus
  output ilb_pkg::ilb_bus_t sb_bus,
  input wire logic [31:0] sb_rdata
);

  if (LAT < 1 || LAT > 15) begin : g_chk
    $error("LAT must lie in 1..15");
  end

  localparam int ISSUE_LAT = LAT + 1;

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_WAIT = 2'b01,
    SS_ISSUE = 2'b10,
    SS_DONE = 2'b11
  } ilb_sstate_t;

  ilb_sstate_t st_r;
  ilb_sstate_t st_nxt;
  logic [3:0] cnt_r;

  wire logic wait_end = (st_r == SS_WAIT) && (cnt_r == 4'h0);
  assign busy = (st_r != SS_IDLE);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SS_IDLE: if (push) st_nxt = SS_WAIT;
      SS_WAIT: if (wait_end) st_nxt = SS_ISSUE;
      SS_ISSUE: st_nxt = SS_DONE;
      SS_DONE: st_nxt = SS_IDLE;
      default: st_nxt = SS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // slow-bus beat pacing
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= SS_IDLE;
      cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (push && !busy) cnt_r <= 4'(LAT - 1);
      else if (st_r == SS_WAIT && cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sb_bus <= '0;
      int_acc <= 1'b0;
    end else begin
      if (push && !busy) begin
        sb_bus.write <= push_write;
        sb_bus.addr <= push_addr;
        sb_bus.wdata <= push_wdata;
      end
      sb_bus.req <= wait_end && !int_hit;
      int_acc <= wait_end && int_hit;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      done <= (st_r == SS_ISSUE);
      if (st_r == SS_ISSUE) rdata <= int_acc ? int_rdata : sb_rdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_slow_issue: assert property (@(posedge clock) disable iff (!resetn)
    push && !busy |-> ##[ISSUE_LAT:ISSUE_LAT] (sb_bus.req || int_acc)
    ##1 done)
    else $error("slow access not issued after its beat wait");

endmodule
`default_nettype wire

/* test/ilb_slave_model.sv */
// Purpose: local, fast and slow bus slave memories behind the interconnect
// Assumes: one word access per req pulse, no byte lanes
// Notes: outside a req the read data is a pattern that changes each cycle
`timescale 1ns/1ps
`default_nettype none
module ilb_slave_model (
  // clock
  input wire logic clock,
  // bus accesses
  input wire ilb_pkg::ilb_bus_t lm_bus,
  input wire ilb_pkg::ilb_bus_t fb_bus,
  input wire ilb_pkg::ilb_bus_t sb_bus,
  // read data
  output logic [31:0] lm_rdata,
  output logic [31:0] fb_rdata,
  output logic [31:0] sb_rdata,
  // access counts seen per bus
  output logic [31:0] lm_cnt,
  output logic [31:0] fb_cnt,
  output logic [31:0] sb_cnt
);
  // one store for all buses: the address regions never overlap
  logic [31:0] mem [logic [31:0]];
  logic [31:0] pat_q = 32'hA5A5_5A5A;
  // counts kept in local variables so each output has a single driver
  logic [31:0] lm_q = 32'h0;
  logic [31:0] fb_q = 32'h0;
  logic [31:0] sb_q = 32'h0;

  assign lm_cnt = lm_q;
  assign fb_cnt = fb_q;
  assign sb_cnt = sb_q;

  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'h0;
  endfunction

  // stale data would let a late sample pass, so idle reads are junk
  always @* begin
    lm_rdata = lm_bus.req ? rd(lm_bus.addr) : pat_q;
    fb_rdata = fb_bus.req ? rd(fb_bus.addr) : ~pat_q;
    sb_rdata = sb_bus.req ? rd(sb_bus.addr) : pat_q ^ 32'h0F0F_0F0F;
  end

  always @(posedge clock) begin
    pat_q <= {pat_q[30:0], pat_q[31]} + 32'h1;
    if (lm_bus.req === 1'b1) begin
      lm_q <= lm_q + 32'h1;
      if (lm_bus.write) mem[lm_bus.addr] = lm_bus.wdata;
    end
    if (fb_bus.req === 1'b1) begin
      fb_q <= fb_q + 32'h1;
      if (fb_bus.write) mem[fb_bus.addr] = fb_bus.wdata;
    end
    if (sb_bus.req === 1'b1) begin
      sb_q <= sb_q + 32'h1;
      if (sb_bus.write) mem[sb_bus.addr] = sb_bus.wdata;
    end
  end
endmodule
`default_nettype wire

/* test/ilb_interconnect_tb.sv */
// Purpose: self-checking bench for the bus interconnect and init lock
// Assumes: masters drive at the falling edge and drop valid on done
// Notes: slow writes are posted, so dependent steps read back first
`timescale 1ns/1ps
`default_nettype none
module ilb_interconnect_tb;
  logic clock;
  logic resetn;
  ilb_pkg::ilb_req_t [ilb_pkg::NMST-1:0] mst_req;
  ilb_pkg::ilb_rsp_t [ilb_pkg::NMST-1:0] mst_rsp;
  ilb_pkg::ilb_bus_t lm_bus;
  ilb_pkg::ilb_bus_t fb_bus;
  ilb_pkg::ilb_bus_t sb_bus;
  logic [31:0] lm_rdata;
  logic [31:0] fb_rdata;
  logic [31:0] sb_rdata;
  logic [31:0] lm_cnt;
  logic [31:0] fb_cnt;
  logic [31:0] sb_cnt;
  logic init_lock;
  logic eth_cause_valid;
  logic [31:0] eth_cause;
  logic eth_pending;
  logic got_err;
  logic [31:0] got_data;
  logic [31:0] cnt0;
  int got_lat;
  int bad_count;
  int checked;
  localparam logic [31:0] PCI_CLK = 32'hF040_0000;
  localparam logic [31:0] SSC_CLK = 32'hF000_0A00;

  ilb_interconnect i_dut (.clock(clock), .resetn(resetn),
    .mst_req(mst_req), .mst_rsp(mst_rsp), .lm_bus(lm_bus),
    .lm_rdata(lm_rdata), .fb_bus(fb_bus), .fb_rdata(fb_rdata),
    .sb_bus(sb_bus), .sb_rdata(sb_rdata), .init_lock(init_lock),
    .eth_cause_valid(eth_cause_valid), .eth_cause(eth_cause),
    .eth_pending(eth_pending));

  ilb_slave_model i_slaves (.clock(clock), .lm_bus(lm_bus),
    .fb_bus(fb_bus), .sb_bus(sb_bus), .lm_rdata(lm_rdata),
    .fb_rdata(fb_rdata), .sb_rdata(sb_rdata), .lm_cnt(lm_cnt),
    .fb_cnt(fb_cnt), .sb_cnt(sb_cnt));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // report and compare
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("counts: checked=%0d bad=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  // one transfer of master m; waits for done, bounded
  task automatic xfer(input int m, input logic wr, input logic sup,
                      input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clock);
    mst_req[m] = '{valid: 1'b1, write: wr, sup: sup, addr: a, wdata: d};
    do begin
      @(negedge clock);
      n++;
    end while (mst_rsp[m].done !== 1'b1 && n < 40);
    got_err = mst_rsp[m].err;
    got_data = mst_rsp[m].rdata;
    got_lat = n;
    mst_req[m].valid = 1'b0;
    if (mst_rsp[m].done !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t no done from master %0d", $time, m);
      final_report();
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk_bit(init_lock, 1'b0, "lock at reset");
    chk_bit(eth_pending, 1'b0, "pending at reset");
    chk_word(32'(mst_rsp[0]), 32'h0, "cpu response at reset");
    $display("test reset done");
  endtask

  task automatic t_routes();
    xfer(0, 1'b1, 1'b1, 32'hF100_0000, 32'h1234_5678);
    chk_word(32'(got_lat), 32'(ilb_pkg::LF_CYC + 2),
             "fast write latency");
    chk_bit(got_err, 1'b0, "fast write err");
    xfer(0, 1'b1, 1'b1, 32'hD000_0010, 32'h0BAD_CAFE);
    xfer(1, 1'b0, 1'b0, 32'hD000_0010, 32'h0);
    chk_word(got_data, 32'h0BAD_CAFE, "fast master reads local");
    chk_word(lm_cnt, 32'h2, "local bus accesses");
    xfer(2, 1'b0, 1'b1, 32'hD000_0010, 32'h0);
    chk_word(got_data, 32'h0BAD_CAFE, "slow master reads local");
    cnt0 = sb_cnt;
    xfer(0, 1'b1, 1'b1, 32'hF000_1000, 32'h5555_AAAA);
    xfer(1, 1'b0, 1'b1, 32'hF000_1000, 32'h0);
    chk_word(got_data, 32'h5555_AAAA, "local to slow read back");
    chk_word(sb_cnt, cnt0 + 32'h2, "slow bus accesses");
    xfer(2, 1'b1, 1'b1, 32'hF100_0040, 32'hC0DE_0001);
    xfer(2, 1'b0, 1'b1, 32'hF100_0040, 32'h0);
    chk_word(got_data, 32'hC0DE_0001, "slow master to fast");
    $display("test routes done");
  endtask

  task automatic t_lock();
    cnt0 = fb_cnt;
    xfer(0, 1'b1, 1'b0, PCI_CLK, 32'h0000_0001);
    chk_bit(got_err, 1'b1, "user write refused");
    chk_word(fb_cnt, cnt0, "refused write reached bus");
    xfer(0, 1'b1, 1'b0, ilb_pkg::WDT_ADDR, 32'h0000_0001);
    chk_bit(got_err, 1'b1, "user watchdog write");
    // set the lock, then hit a protected register before it lands
    xfer(0, 1'b1, 1'b1, ilb_pkg::WDT_ADDR, 32'h0000_0001);
    xfer(0, 1'b1, 1'b1, PCI_CLK, 32'h0000_0002);
    chk_bit(got_err, 1'b0, "write overtakes posted lock");
    xfer(0, 1'b0, 1'b1, ilb_pkg::WDT_ADDR, 32'h0);
    chk_word(got_data, 32'h0000_0001, "watchdog holds lock");
    chk_bit(init_lock, 1'b1, "lock line high");
    cnt0 = fb_cnt;
    xfer(0, 1'b1, 1'b1, PCI_CLK, 32'h0000_0003);
    chk_word(32'(got_lat), 32'(ilb_pkg::LF_CYC + 1),
             "refusal latency");
    chk_bit(got_err, 1'b1, "locked write refused");
    chk_word(fb_cnt, cnt0, "locked write reached bus");
    cnt0 = sb_cnt;
    xfer(0, 1'b1, 1'b1, SSC_CLK, 32'h0000_0001);
    chk_bit(got_err, 1'b1, "slow protected error");
    chk_word(sb_cnt, cnt0, "slow refused write reached bus");
    $display("test lock done");
  endtask

  task automatic t_unlock();
    xfer(0, 1'b1, 1'b1, ilb_pkg::WDT_ADDR, 32'h0000_0000);
    xfer(0, 1'b0, 1'b1, ilb_pkg::WDT_ADDR, 32'h0);
    chk_bit(init_lock, 1'b0, "lock line cleared");
    xfer(0, 1'b1, 1'b1, SSC_CLK, 32'h0000_0001);
    chk_bit(got_err, 1'b0, "unlocked slow write");
    xfer(0, 1'b0, 1'b1, PCI_CLK, 32'h0);
    chk_word(got_data, 32'h0000_0002, "target kept last good");
    xfer(0, 1'b1, 1'b1, ilb_pkg::WDT_ADDR, 32'h0000_0001);
    xfer(0, 1'b0, 1'b1, SSC_CLK, 32'h0);
    chk_word(got_data, 32'h0000_0001, "slow protected stored");
    chk_bit(init_lock, 1'b1, "lock set again");
    $display("test unlock done");
  endtask

  task automatic t_eth();
    @(negedge clock);
    eth_cause_valid = 1'b1;
    eth_cause = 32'hCA5E_0001;
    @(negedge clock);
    eth_cause = 32'hCA5E_0002;
    @(negedge clock);
    eth_cause_valid = 1'b0;
    chk_bit(eth_pending, 1'b1, "pending on cause");
    xfer(0, 1'b1, 1'b1, ilb_pkg::ETH_SRV_ADDR, 32'h0000_4000);
    xfer(0, 1'b0, 1'b1, ilb_pkg::ETH_SRV_ADDR, 32'h0);
    chk_bit(got_data[ilb_pkg::ETH_PEND_BIT], 1'b0,
            "pending cleared");
    xfer(0, 1'b0, 1'b1, ilb_pkg::ETH_FIFO_ADDR, 32'h0);
    chk_word(got_data, 32'hCA5E_0001, "first cause");
    repeat (2) @(negedge clock);
    chk_bit(eth_pending, 1'b1, "pending raised again");
    xfer(0, 1'b1, 1'b1, ilb_pkg::ETH_SRV_ADDR, 32'h0000_4000);
    xfer(0, 1'b0, 1'b1, ilb_pkg::WDT_ADDR, 32'h0);
    xfer(0, 1'b0, 1'b1, ilb_pkg::ETH_FIFO_ADDR, 32'h0);
    chk_word(got_data, 32'hCA5E_0002, "second cause");
    repeat (2) @(negedge clock);
    chk_bit(eth_pending, 1'b0, "no pending when empty");
    $display("test eth done");
  endtask

  initial begin
    resetn = 1'b0;
    mst_req = '0;
    eth_cause_valid = 1'b0;
    eth_cause = 32'h0;
    bad_count = 0;
    checked = 0;
    repeat (8) @(negedge clock);
    t_reset();
    resetn = 1'b1;
    t_routes();
    t_lock();
    t_unlock();
    t_eth();
    final_report();
  end
endmodule
`default_nettype wire
